/* hw/tdc_map.svh */
`ifndef TDC_MAP_SVH
`define TDC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define TDC_CTRL 8'h00
`define TDC_CT_RATIO 8'h04
`define TDC_VOLT_RATIO 8'h08
`define TDC_TAP 8'h0C
`define TDC_THR_STA 8'h10
`define TDC_THR_TRA 8'h14
`define TDC_BASE 8'h18
`define TDC_OFFSET 8'h1C
`define TDC_TTRANS 8'h20
`define TDC_STATUS 8'h24

// ****************************************
// Field positions
// ****************************************
`define TDC_F_H2EN 0
`define TDC_F_H4EN 1
`define TDC_F_H5EN 2
`define TDC_F_CROSS 3
`define TDC_F_SATEN 4
`define TDC_F_GRP 8
`define TDC_F_W1C 12
`define TDC_F_W2C 16

// ****************************************
// Reset values
// ****************************************
`define TDC_CTRL_RST 32'h0000_0000
`define TDC_RATIO_RST 16'h1000
`define TDC_TAP_RST 16'h0000
`define TDC_THR_STA_RST 24'h1E_1E1E
`define TDC_THR_TRA_RST 24'h0F_0F0F
`define TDC_BASE_RST 16'h1000
`define TDC_OFFSET_RST 16'h0000
`define TDC_TTRANS_RST 16'h07D0

// ****************************************
// Arithmetic and timing
// ****************************************
`define TDC_FRAC 12
`define TDC_ONE 17'h0_1000
`define TDC_INV_SQRT3 17'h0_093D
`define TDC_THIRD_FRAC 16
`define TDC_ONE_THIRD 18'h0_5555
`define TDC_LOW_MULT 5'h14
`define TDC_CLK_NS 10
`define TDC_TICK_NS 1000000
`define TDC_SAT_BLOCK_MS 300

`endif

/* hw/tdc_pkg.sv */
package tdc_pkg;
  typedef enum logic [2:0] {
    TDC_STAR,
    TDC_DELTA,
    TDC_ZIGZAG,
    TDC_STAR_GND,
    TDC_ZIGZAG_GND
  } tdc_conn_t;

  typedef enum logic {
    TDC_DIV_IDLE,
    TDC_DIV_RUN
  } tdc_div_st_t;
endpackage

/* hw/tdc_rotate.sv */
`timescale 1ns/1ps
`include "tdc_map.svh"

module tdc_rotate #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Incoming amplitude-matched winding 2 phases
  input wire logic in_valid,
  input wire logic [3:0] group,
  input wire logic signed [W-1:0] x0,
  input wire logic signed [W-1:0] x1,
  input wire logic signed [W-1:0] x2,
  // Rotated phases
  output logic out_valid,
  output logic signed [W-1:0] y0,
  output logic signed [W-1:0] y1,
  output logic signed [W-1:0] y2
);
  // Odd groups are group-1 applied after the phase differences
  wire odd = group[0];
  wire [2:0] half = group[3:1];
  wire [1:0] shift = half >= 3'h6 ? 2'(half - 3'h6) : half >= 3'h3 ? 2'(half - 3'h3) : half[1:0];
  wire neg = half[0];
  logic signed [W-1:0] xa [3];
  logic signed [W-1:0] va [3];
  logic signed [W-1:0] ya [3];
  assign xa[0] = x0;
  assign xa[1] = x1;
  assign xa[2] = x2;

  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_row
      localparam logic [2:0] RN = 3'(r);
      localparam int NX = (r + 1) % 3;
      wire signed [W:0] diff = {xa[r][W-1], xa[r]} - {xa[NX][W-1], xa[NX]};
      wire signed [W+17:0] scaled = diff * $signed(`TDC_INV_SQRT3);
      wire signed [W+17:0] sh = scaled >>> `TDC_FRAC;
      wire [2:0] sum = {1'b0, shift} + RN;
      wire [1:0] idx = sum >= 3'h3 ? 2'(sum - 3'h3) : sum[1:0];
      assign va[r] = odd ? sh[W-1:0] : xa[r];
      assign ya[r] = neg ? -va[idx] : va[idx];
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      y0 <= '0;
      y1 <= '0;
      y2 <= '0;
    end else begin
      out_valid <= in_valid;
      y0 <= ya[0];
      y1 <= ya[1];
      y2 <= ya[2];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_rot_group4;
    in_valid && group == 4'h4 |=> y0 == $past(x2) && y1 == $past(x0) && y2 == $past(x1);
  endproperty
  a_rot_group4: assert property (p_rot_group4) else $error("group 4 permutation wrong");

  property p_rot_group6;
    in_valid && group == 4'h6 |=> y0 == -$past(x0) && y2 == -$past(x2);
  endproperty
  a_rot_group6: assert property (p_rot_group6) else $error("group 6 negation wrong");
endmodule // tdc_rotate

/* hw/tdc_top.sv */
`timescale 1ns/1ps
`include "tdc_map.svh"

module tdc_top #(
  parameter int DW = 16,
  parameter int W = 20,
  parameter int MS_CYCLES = `TDC_TICK_NS / `TDC_CLK_NS,
  parameter int SAT_BLOCK_MS = `TDC_SAT_BLOCK_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Phase samples
  input wire logic smp_valid,
  input wire logic signed [DW-1:0] w1_ia,
  input wire logic signed [DW-1:0] w1_ib,
  input wire logic signed [DW-1:0] w1_ic,
  input wire logic signed [DW-1:0] w2_ia,
  input wire logic signed [DW-1:0] w2_ib,
  input wire logic signed [DW-1:0] w2_ic,
  // Per-phase measurements, phase 0 in the low slice
  input wire logic [47:0] id_mag,
  input wire logic [47:0] is_mag,
  input wire logic [23:0] h2_ratio,
  input wire logic [23:0] h4_ratio,
  input wire logic [23:0] h5_ratio,
  input wire logic [2:0] zero_cross,
  // Compensated phases
  output logic comp_valid,
  output logic signed [W-1:0] w1_oa,
  output logic signed [W-1:0] w1_ob,
  output logic signed [W-1:0] w1_oc,
  output logic signed [W-1:0] w2_oa,
  output logic signed [W-1:0] w2_ob,
  output logic signed [W-1:0] w2_oc,
  // Restraint results
  output logic [47:0] curve_offset,
  output logic [2:0] harm_restrain,
  output logic [2:0] sat_external,
  output logic transient_active
);
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [15:0] ct_ratio_r, volt_ratio_r, base_current, offset_r, t_trans_r, kr_r;
  logic signed [15:0] tap_r;
  logic [23:0] thr_sta_r, thr_tra_r;
  logic div_busy;
  logic [31:0] rd_mux;

  wire wr_ratio = reg_wr && (reg_addr == `TDC_CT_RATIO || reg_addr == `TDC_VOLT_RATIO ||
                             reg_addr == `TDC_TAP);
  wire second_harmonic_restraint_enable = ctrl_r[`TDC_F_H2EN];
  wire fourth_harmonic_restraint_enable = ctrl_r[`TDC_F_H4EN];
  wire fifth_harmonic_restraint_enable = ctrl_r[`TDC_F_H5EN];
  wire cross_block_enable = ctrl_r[`TDC_F_CROSS];
  wire saturation_stabilization_enable = ctrl_r[`TDC_F_SATEN];
  wire [3:0] phase_group = ctrl_r[`TDC_F_GRP +: 4];
  tdc_pkg::tdc_conn_t primary_winding_connection;
  tdc_pkg::tdc_conn_t secondary_winding_connection;
  assign primary_winding_connection = tdc_pkg::tdc_conn_t'(ctrl_r[`TDC_F_W1C +: 3]);
  assign secondary_winding_connection = tdc_pkg::tdc_conn_t'(ctrl_r[`TDC_F_W2C +: 3]);
  wire w1_gnd = primary_winding_connection == tdc_pkg::TDC_STAR_GND ||
                primary_winding_connection == tdc_pkg::TDC_ZIGZAG_GND;
  // Without an odd group the delta side blocks ground current anyway
  wire w2_gnd = phase_group[0] && (secondary_winding_connection == tdc_pkg::TDC_STAR_GND ||
                secondary_winding_connection == tdc_pkg::TDC_ZIGZAG_GND);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `TDC_CTRL_RST;
      ct_ratio_r <= `TDC_RATIO_RST;
      volt_ratio_r <= `TDC_RATIO_RST;
      tap_r <= `TDC_TAP_RST;
      thr_sta_r <= `TDC_THR_STA_RST;
      thr_tra_r <= `TDC_THR_TRA_RST;
      base_current <= `TDC_BASE_RST;
      offset_r <= `TDC_OFFSET_RST;
      t_trans_r <= `TDC_TTRANS_RST;
    end else if (reg_wr) begin
      if (reg_addr == `TDC_CTRL) ctrl_r <= reg_wdata;
      else if (reg_addr == `TDC_CT_RATIO) ct_ratio_r <= reg_wdata[15:0];
      else if (reg_addr == `TDC_VOLT_RATIO) volt_ratio_r <= reg_wdata[15:0];
      else if (reg_addr == `TDC_TAP) tap_r <= reg_wdata[15:0];
      else if (reg_addr == `TDC_THR_STA) thr_sta_r <= reg_wdata[23:0];
      else if (reg_addr == `TDC_THR_TRA) thr_tra_r <= reg_wdata[23:0];
      else if (reg_addr == `TDC_BASE) base_current <= reg_wdata[15:0];
      else if (reg_addr == `TDC_OFFSET) offset_r <= reg_wdata[15:0];
      else if (reg_addr == `TDC_TTRANS) t_trans_r <= reg_wdata[15:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == `TDC_CTRL) rd_mux = ctrl_r;
    else if (reg_addr == `TDC_CT_RATIO) rd_mux = {16'h0000, ct_ratio_r};
    else if (reg_addr == `TDC_VOLT_RATIO) rd_mux = {16'h0000, volt_ratio_r};
    else if (reg_addr == `TDC_TAP) rd_mux = {16'h0000, tap_r};
    else if (reg_addr == `TDC_THR_STA) rd_mux = {8'h00, thr_sta_r};
    else if (reg_addr == `TDC_THR_TRA) rd_mux = {8'h00, thr_tra_r};
    else if (reg_addr == `TDC_BASE) rd_mux = {16'h0000, base_current};
    else if (reg_addr == `TDC_OFFSET) rd_mux = {16'h0000, offset_r};
    else if (reg_addr == `TDC_TTRANS) rd_mux = {16'h0000, t_trans_r};
    else if (reg_addr == `TDC_STATUS)
      rd_mux = {kr_r, 8'h00, div_busy, transient_active, sat_external, harm_restrain};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // ****************************************
  // Ratio divider
  // ****************************************
  // Serial divide trades 33 cycles of latency (one load, 32 steps) for no wide divider
  tdc_pkg::tdc_div_st_t div_st_r;
  logic [5:0] div_cnt_r;
  logic [31:0] div_num_r, div_quo_r;
  logic [32:0] div_rem_r;
  logic [16:0] div_den_r;
  wire [32:0] rem_sh = {div_rem_r[31:0], div_num_r[31]};
  wire rem_ge = rem_sh >= {16'h0000, div_den_r};
  wire [31:0] quo_nxt = {div_quo_r[30:0], rem_ge};
  assign div_busy = div_st_r == tdc_pkg::TDC_DIV_RUN;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_st_r <= tdc_pkg::TDC_DIV_IDLE;
      div_cnt_r <= '0;
      div_num_r <= '0;
      div_quo_r <= '0;
      div_rem_r <= '0;
      div_den_r <= `TDC_ONE;
      kr_r <= `TDC_RATIO_RST;
    end else if (wr_ratio) begin
      div_st_r <= tdc_pkg::TDC_DIV_RUN;
      div_cnt_r <= '0;
    end else begin
      case (div_st_r)
        tdc_pkg::TDC_DIV_IDLE: begin
          div_num_r <= ct_ratio_r * volt_ratio_r;
          div_den_r <= 17'(`TDC_ONE + {{1{tap_r[15]}}, tap_r});
          div_rem_r <= '0;
          div_quo_r <= '0;
        end
        tdc_pkg::TDC_DIV_RUN: begin
          if (div_cnt_r == 6'h00) begin
            div_num_r <= ct_ratio_r * volt_ratio_r;
            div_den_r <= 17'(`TDC_ONE + {{1{tap_r[15]}}, tap_r});
            div_rem_r <= '0;
            div_quo_r <= '0;
            div_cnt_r <= 6'h01;
          end else begin
            div_num_r <= {div_num_r[30:0], 1'b0};
            div_rem_r <= rem_ge ? rem_sh - {16'h0000, div_den_r} : rem_sh;
            div_quo_r <= quo_nxt;
            div_cnt_r <= 6'(div_cnt_r + 6'h01);
            if (div_cnt_r == 6'h20) begin
              div_st_r <= tdc_pkg::TDC_DIV_IDLE;
              kr_r <= |quo_nxt[31:16] ? 16'hFFFF : quo_nxt[15:0];
            end
          end
        end
        default: div_st_r <= tdc_pkg::TDC_DIV_IDLE;
      endcase
    end
  end

  // ****************************************
  // Compensation pipeline
  // ****************************************
  logic signed [DW-1:0] w1_in [3];
  logic signed [DW-1:0] w2_in [3];
  logic signed [W-1:0] w1a_r [3];
  logic signed [W-1:0] w2a_r [3];
  logic signed [W-1:0] w1b_r [3];
  logic signed [W-1:0] rot [3];
  logic signed [W-1:0] w1_nxt [3];
  logic signed [W-1:0] w2_nxt [3];
  logic va_r, vb;
  assign w1_in[0] = w1_ia;
  assign w1_in[1] = w1_ib;
  assign w1_in[2] = w1_ic;
  assign w2_in[0] = w2_ia;
  assign w2_in[1] = w2_ib;
  assign w2_in[2] = w2_ic;

  wire signed [W+1:0] sum1 = w1b_r[0] + w1b_r[1] + w1b_r[2];
  wire signed [W+1:0] sum2 = rot[0] + rot[1] + rot[2];
  wire signed [W+19:0] z1p = sum1 * $signed(`TDC_ONE_THIRD);
  wire signed [W+19:0] z2p = sum2 * $signed(`TDC_ONE_THIRD);
  wire signed [W+19:0] z1s = z1p >>> `TDC_THIRD_FRAC;
  wire signed [W+19:0] z2s = z2p >>> `TDC_THIRD_FRAC;
  wire signed [W-1:0] z1 = z1s[W-1:0];
  wire signed [W-1:0] z2 = z2s[W-1:0];

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_amp
      wire signed [DW+16:0] prod = w2_in[p] * $signed({1'b0, kr_r});
      wire signed [DW+16:0] sh = prod >>> `TDC_FRAC;
      // Winding 1 passes unscaled as the reference side
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          w1a_r[p] <= '0;
          w2a_r[p] <= '0;
          w1b_r[p] <= '0;
        end else begin
          w1a_r[p] <= W'(w1_in[p]);
          w2a_r[p] <= sh[W-1:0];
          w1b_r[p] <= w1a_r[p];
        end
      end
      assign w1_nxt[p] = w1_gnd ? w1b_r[p] - z1 : w1b_r[p];
      assign w2_nxt[p] = w2_gnd ? rot[p] - z2 : rot[p];
    end
  endgenerate

  // Rotation sits between matching and zero removal
  tdc_rotate #(.W(W)) tdc_rotate_inst (
    .clk(clk),
    .reset(reset),
    .in_valid(va_r),
    .group(phase_group),
    .x0(w2a_r[0]),
    .x1(w2a_r[1]),
    .x2(w2a_r[2]),
    .out_valid(vb),
    .y0(rot[0]),
    .y1(rot[1]),
    .y2(rot[2])
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      va_r <= 1'b0;
      comp_valid <= 1'b0;
      {w1_oa, w1_ob, w1_oc, w2_oa, w2_ob, w2_oc} <= '0;
    end else begin
      va_r <= smp_valid;
      comp_valid <= vb;
      {w1_oa, w1_ob, w1_oc} <= {w1_nxt[0], w1_nxt[1], w1_nxt[2]};
      {w2_oa, w2_ob, w2_oc} <= {w2_nxt[0], w2_nxt[1], w2_nxt[2]};
    end
  end

  // ****************************************
  // Restraint
  // ****************************************
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] trans_cnt_r;
  logic [15:0] sat_cnt_r [3];
  logic [2:0] qual, low, sat_nxt;
  wire quiet = &low;
  wire [23:0] thr = transient_active ? thr_tra_r : thr_sta_r;
  wire [2:0] harm_nxt = cross_block_enable ? {3{|qual}} : qual;

  generate
    for (p = 0; p < 3; p++) begin : g_phase
      wire [15:0] idm = id_mag[16*p +: 16];
      wire [15:0] ism = is_mag[16*p +: 16];
      wire zc = saturation_stabilization_enable && zero_cross[p];
      wire ext = ism > idm;
      assign low[p] = idm * `TDC_LOW_MULT < {5'h00, base_current} &&
                      ism * `TDC_LOW_MULT < {5'h00, base_current};
      assign qual[p] = (second_harmonic_restraint_enable && h2_ratio[8*p +: 8] > thr[7:0]) ||
                       (fourth_harmonic_restraint_enable && h4_ratio[8*p +: 8] > thr[15:8]) ||
                       (fifth_harmonic_restraint_enable && h5_ratio[8*p +: 8] > thr[23:16]);
      assign sat_nxt[p] = sat_cnt_r[p] != 16'h0000;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) sat_cnt_r[p] <= '0;
        else if (!saturation_stabilization_enable) sat_cnt_r[p] <= '0;
        else if (zc && ext) sat_cnt_r[p] <= 16'(SAT_BLOCK_MS);
        else if (zc) sat_cnt_r[p] <= '0;
        else if (tick_r && sat_nxt[p]) sat_cnt_r[p] <= 16'(sat_cnt_r[p] - 16'h0001);
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) curve_offset[16*p +: 16] <= '0;
        else curve_offset[16*p +: 16] <= harm_nxt[p] || sat_nxt[p] ? offset_r : 16'h0000;
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      trans_cnt_r <= '0;
      transient_active <= 1'b0;
      harm_restrain <= '0;
      sat_external <= '0;
    end else begin
      tick_r <= tick_cnt_r == 32'(MS_CYCLES - 1);
      tick_cnt_r <= tick_cnt_r == 32'(MS_CYCLES - 1) ? '0 : 32'(tick_cnt_r + 32'h1);
      if (quiet) trans_cnt_r <= t_trans_r;
      else if (tick_r && trans_cnt_r != 16'h0000) trans_cnt_r <= 16'(trans_cnt_r - 16'h0001);
      transient_active <= trans_cnt_r != 16'h0000;
      harm_restrain <= harm_nxt;
      sat_external <= sat_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire signed [W+1:0] w1_out_sum = w1_oa + w1_ob + w1_oc;

  property p_pipe;
    comp_valid == $past(smp_valid, 3);
  endproperty
  a_pipe: assert property (p_pipe) else $error("latency not three cycles");
  property p_w1_zero;
    comp_valid && $past(w1_gnd) |-> w1_out_sum <= 32 && w1_out_sum >= -32;
  endproperty
  a_w1_zero: assert property (p_w1_zero) else $error("winding 1 zero sequence left");
  property p_w1_thru;
    comp_valid && $past(!w1_gnd) |-> w1_oa == W'($past(w1_ia, 3));
  endproperty
  a_w1_thru: assert property (p_w1_thru) else $error("winding 1 altered");
  property p_raise;
    harm_restrain[0] || sat_external[0] |-> curve_offset[15:0] == $past(offset_r);
  endproperty
  a_raise: assert property (p_raise) else $error("offset not added");
  property p_unraised;
    !harm_restrain[0] && !sat_external[0] |-> curve_offset[15:0] == 16'h0000;
  endproperty
  a_unraised: assert property (p_unraised) else $error("curve raised");
  property p_enable;
    harm_restrain != 3'h0 |-> $past(ctrl_r[2:0]) != 3'h0;
  endproperty
  a_enable: assert property (p_enable) else $error("restraint without enable");
  property p_cross;
    $past(cross_block_enable) && harm_restrain != 3'h0 |-> harm_restrain == 3'h7;
  endproperty
  a_cross: assert property (p_cross) else $error("cross blocking incomplete");
  property p_restart;
    quiet |=> trans_cnt_r == $past(t_trans_r)
      ##1 transient_active == ($past(t_trans_r, 2) != 16'h0000);
  endproperty
  a_restart: assert property (p_restart) else $error("window not restarted");
  property p_sat;
    saturation_stabilization_enable && zero_cross[0] && is_mag[15:0] > id_mag[15:0]
      |=> sat_cnt_r[0] == 16'(SAT_BLOCK_MS) ##1 sat_external[0];
  endproperty
  a_sat: assert property (p_sat) else $error("external fault missed");
  property p_div;
    wr_ratio |=> div_busy ##[1:40] !div_busy;
  endproperty
  a_div: assert property (p_div) else $error("ratio divide stuck");

  c_transient: cover property (quiet ##1 !quiet ##1 transient_active);
  c_sat_ext: cover property (sat_external[0] && curve_offset[15:0] != 16'h0000);
  c_cross: cover property (cross_block_enable && harm_restrain == 3'h7);
endmodule // tdc_top

/* sim/tdc_ct_model.sv */
`timescale 1ns/1ps

module tdc_ct_model (
  // Clock
  input wire logic clk,
  // Request from bench
  input wire logic fire,
  input wire logic [95:0] pat,
  // Phase samples, six 16-bit currents
  output logic smp_valid = 1'b0,
  output logic [95:0] smp = 96'h0
);
  // ****************************************
  // Current transformer sampler
  // ****************************************
  // Between strobes the lines flip so a stale sample can never pass as fresh
  // Known idle level from time zero, so latency checks see no unknown strobe
  always @(posedge clk) begin
    smp_valid <= fire;
    smp <= fire ? pat : ~smp;
  end
endmodule // tdc_ct_model

/* sim/transformer_diff_compensation_bench.sv */
`timescale 1ns/1ps

module transformer_diff_compensation_bench;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic [95:0] pat = 96'h0, smp;
  logic smp_valid, comp_valid, transient_active;
  logic [47:0] id_mag = 48'h0, is_mag = 48'h0, curve_offset;
  logic [23:0] h2 = 24'h0, h4 = 24'h0, h5 = 24'h0;
  logic [2:0] zc = 3'h0, harm_restrain, sat_external;
  wire signed [19:0] o [6];
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h3C};
  logic [31:0] rv [8] = '{32'h0, 32'h1000, 32'h0, 32'h1E_1E1E, 32'h0F_0F0F, 32'h1000,
    32'h7D0, 32'h0};
  int x [3] = '{400, 100, -50};
  int fail_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;

  tdc_ct_model tdc_ct_model_inst (.clk(clk), .fire(fire), .pat(pat), .smp_valid(smp_valid),
    .smp(smp));
  // Short millisecond tick and saturation hold keep the run brief
  tdc_top #(.MS_CYCLES(10), .SAT_BLOCK_MS(3)) tdc_top_inst (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .smp_valid(smp_valid), .w1_ia(smp[15:0]), .w1_ib(smp[31:16]),
    .w1_ic(smp[47:32]), .w2_ia(smp[63:48]), .w2_ib(smp[79:64]), .w2_ic(smp[95:80]),
    .id_mag(id_mag), .is_mag(is_mag), .h2_ratio(h2), .h4_ratio(h4), .h5_ratio(h5),
    .zero_cross(zc), .comp_valid(comp_valid), .w1_oa(o[0]), .w1_ob(o[1]), .w1_oc(o[2]),
    .w2_oa(o[3]), .w2_ob(o[4]), .w2_oc(o[5]), .curve_offset(curve_offset),
    .harm_restrain(harm_restrain), .sat_external(sat_external),
    .transient_active(transient_active));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic signed [47:0] seen, exp, input int tol);
    logic signed [47:0] d;
    d = seen - exp;
    samples_checked++;
    if ((tol == 0) ? (seen !== exp) : ($isunknown(seen) || d > tol || d < -tol)) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_t(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd = reg_rdata;
  endtask

  task automatic send(input logic [95:0] p);
    pat <= p;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (int n = 0; n < 10; n++) begin
      @(posedge clk);
      if (comp_valid === 1'b1)
        return;
    end
    check("comp_valid", 1'b0, 1'b1, 0);
    final_report();
  endtask

  function automatic logic [95:0] pk(input int a, b, c, d, e, f);
    return {16'(f), 16'(e), 16'(d), 16'(c), 16'(b), 16'(a)};
  endfunction

  // Odd groups are the even group below applied to phase differences
  function automatic int rot(input int v [3], input int g, input int i);
    int d [3];
    int r;
    for (int k = 0; k < 3; k++)
      d[k] = (g % 2) ? v[k] - v[(k + 1) % 3] : v[k];
    r = d[(i + (g / 2) % 3) % 3];
    r = ((g / 2) % 2) ? -r : r;
    return (g % 2) ? r * 2365 / 4096 : r;
  endfunction

  task automatic restr(input logic [4:0] c, input int s, input logic [23:0] v,
    input logic [2:0] e);
    wr(8'h00, {27'h0, c});
    h2 <= (s == 0) ? v : 24'h0;
    h4 <= (s == 1) ? v : 24'h0;
    h5 <= (s == 2) ? v : 24'h0;
    repeat (3) @(posedge clk);
    check("harm_restrain", harm_restrain, e, 0);
    check("curve_offset", curve_offset, {e[2] ? 16'h8 : 16'h0, e[1] ? 16'h8 : 16'h0,
      e[0] ? 16'h8 : 16'h0}, 0);
  endtask

  task automatic sat(input logic [15:0] i, s);
    id_mag <= {3{i}};
    is_mag <= {3{s}};
    zc <= 3'b001;
    @(posedge clk);
    zc <= 3'b000;
    repeat (4) @(posedge clk);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (ra[i]) begin
      rd_t(ra[i]);
      check("reset_value", rd, rv[i], 0);
    end
    $display("registers done");
    for (int g = 0; g < 12; g++) begin
      wr(8'h00, 32'(g) << 8);
      send(pk(300, 200, 100, x[0], x[1], x[2]));
      for (int i = 0; i < 3; i++)
        check("w2_rotated", o[3 + i], rot(x, g, i), g % 2);
    end
    for (int i = 0; i < 3; i++)
      check("w1_plain", o[i], 300 - 100 * i, 0);
    wr(8'h00, 32'h0003_3000);
    send(pk(300, 0, 0, 300, 0, 0));
    check("w1_zero_a", o[0], 200, 2);
    check("w1_zero_b", o[1], -100, 2);
    check("w2_even_kept", o[3], 300, 0);
    wr(8'h00, 32'h0004_4100);
    send(pk(0, 0, 300, 300, 0, 0));
    check("w1_zz_c", o[2], 200, 2);
    check("w2_odd_c", o[5], -173, 2);
    $display("vector groups done");
    wr(8'h04, 32'h3000);
    wr(8'h08, 32'h2000);
    wr(8'h0C, 32'h1000);
    wr(8'h00, 32'h0);
    rd_t(8'h24);
    check("div_busy", rd[7], 1'b1, 0);
    for (int n = 0; n < 60 && rd[7] !== 1'b0; n++)
      rd_t(8'h24);
    check("div_done", rd[7], 1'b0, 0);
    if (rd[7] !== 1'b0)
      final_report();
    check("kr", rd[31:16], 16'h3000, 0);
    send(pk(0, 0, 0, 100, -200, 50));
    check("w2_scaled_a", o[3], 300, 1);
    check("w2_scaled_b", o[4], -600, 1);
    $display("amplitude done");
    wr(8'h1C, 32'h8);
    wr(8'h20, 32'h5);
    restr(5'h01, 0, 24'h00_1000, 3'b010);
    restr(5'h06, 0, 24'h00_1000, 3'b000);
    restr(5'h02, 1, 24'h00_0010, 3'b001);
    restr(5'h04, 2, 24'h10_0000, 3'b100);
    restr(5'h0C, 2, 24'h10_0000, 3'b111);
    restr(5'h04, 2, 24'h0F_0000, 3'b000);
    check("window_on", transient_active, 1'b1, 0);
    id_mag <= {3{16'd300}};
    is_mag <= {3{16'd600}};
    repeat (70) @(posedge clk);
    check("window_off", transient_active, 1'b0, 0);
    restr(5'h01, 0, 24'h00_1000, 3'b000);
    restr(5'h01, 0, 24'h00_1F00, 3'b010);
    h2 <= 24'h0;
    $display("harmonics done");
    wr(8'h00, 32'h10);
    sat(16'd300, 16'd600);
    check("sat_ext", sat_external, 3'b001, 0);
    check("sat_offset", curve_offset, 48'h8, 0);
    sat(16'd600, 16'd300);
    check("sat_int", sat_external, 3'b000, 0);
    wr(8'h00, 32'h0);
    sat(16'd300, 16'd600);
    check("sat_off", sat_external, 3'b000, 0);
    $display("saturation done");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule // transformer_diff_compensation_bench
